// >>> common/mscr_pkg.sv
// Purpose: constants for the meter status, record and config latch bank
// Assumes: records are 32 bits, parity nibble in bits 31:28
// Notes:   config addresses are 6-bit bit indices into a 56-bit latch map, 56-63 reserved
package mscr_pkg;

  localparam int          NUM_RECORDS   = 8;
  localparam int          RECORD_WIDTH  = 32;
  localparam int          DATA_WIDTH    = 28;
  localparam int          PARITY_LSB    = 28;
  localparam int          NUM_CFG_BITS  = 56;
  localparam int          CFG_ADDR_W    = 6;
  localparam int          REC_IDX_W     = 3;

  // status bit positions
  localparam int          STAT_NO_LOAD  = 0;
  localparam int          STAT_MOD_STK  = 1;
  localparam int          STAT_FREQ_OOR = 2;
  localparam int          STAT_TAMPER   = 3;
  localparam int          STAT_CH_SEL   = 4;
  localparam int          STAT_V_TREND  = 5;
  localparam int          STAT_PIN_MIS  = 6;
  localparam int          STAT_INVALID  = 7;

  // record indices
  localparam logic [2:0]  REC_MODE_SIG  = 3'h1;
  localparam logic [2:0]  REC_CFG_LOW   = 3'h6;
  localparam logic [2:0]  REC_CFG_HIGH  = 3'h7;
  localparam int          MODE_SIG_LSB  = 20;
  localparam int          MODE_SIG_W    = 8;

  // config bit addresses
  localparam logic [5:0]  CFG_CLK_RANGE = 6'h01;
  localparam logic [5:0]  CFG_OSC_TYPE  = 6'h02;
  localparam logic [5:0]  CFG_SENSOR    = 6'h05;
  localparam logic [5:0]  CFG_TAMPER_EN = 6'h07;

  // reserved addresses that never latch
  localparam logic [63:0] CFG_RSVD_MASK = 64'hFF00_0000_0003_0059;

  localparam logic [7:0]  STATUS_RESET  = 8'h80;
  localparam logic [55:0] CFG_RESET     = 56'h00_0000_0000_0000;
  localparam logic [7:0]  MODE_RESET    = 8'h00;

endpackage

// >>> rtl/mscr_bank.sv
// Overview of operation
// - bit0 shows no-load detected
// - bit1 shows modulator bitstream stuck
// - bit2 shows line frequency outside 45-65Hz
// - bit3 shows tamper detected
// - bit4 shows secondary current channel chosen
// - bit5 zero while voltage slope positive
// - bit6 shows output pin forced externally
// - bit7 shows records invalid during restart
// - all eight status flags host-readable
// - eight 32-bit records, 4-bit parity nibble
// - parity bit is odd parity of column
// - first six records read-only except mode field
// - config latches cleared by POR and remote reset
// - one byte command writes one config bit
// - clock range select bit at address 1
// - oscillator type select bit at address 2
// - sensor type bit at address 5 with tamper
//
// Purpose: status flags, parity-protected records and config latches
// Assumes: serial framing is decoded elsewhere into strobes here
// Notes:   all inputs synchronous to ref_clk
`timescale 1ns/1ps

module mscr_bank (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        remoteReset,
  // metering condition inputs
  input  wire logic        noLoadDet,
  input  wire logic        modStuckDet,
  input  wire logic        freqOutOfRange,
  input  wire logic        tamperDet,
  input  wire logic        secondaryChanSel,
  input  wire logic        voltSlopeNeg,
  input  wire logic        pinMismatchDet,
  input  wire logic        restartBusy,
  // measurement data for read-only records
  input  wire logic [27:0] measData [0:5],
  // host config bit command
  input  wire logic        cfgWrStb,
  input  wire logic [5:0]  cfgWrAddr,
  input  wire logic        cfgWrVal,
  // host mode-signal write
  input  wire logic        modeWrStb,
  input  wire logic [7:0]  modeWrData,
  // host record read
  input  wire logic [2:0]  recRdIdx,
  // outputs
  output logic [31:0]      recRdData_ff,
  output logic [7:0]       meterStatusFlags_ff,
  output logic             clockRangeSelect_ff,
  output logic             oscillatorTypeSelect_ff,
  output logic             currentSensorType_ff,
  output logic             tamperEnable_ff
);

  // ************************************************************
  // functions
  // ************************************************************
  // odd parity over each bit column of the seven data nibbles:
  // each column plus its parity bit holds an odd count of ones
  function automatic logic [3:0] oddParity(input logic [27:0] d);
    logic [3:0] p;
    p = 4'hF;
    for (int n = 0; n < 7; n++) begin
      p = p ^ d[n*4 +: 4];
    end
    return p;
  endfunction

  // parity nibble on top of the 28-bit value
  function automatic logic [31:0] mkRecord(input logic [27:0] d);
    return {oddParity(d), d};
  endfunction

  // reserved slots and positions 56-63 have no latch behind them
  function automatic logic cfgAddrRsvd(input logic [5:0] a);
    logic [63:0] m;
    m = 64'h0000_0000_0000_0001 << a;
    return (m & mscr_pkg::CFG_RSVD_MASK) != 64'h0000_0000_0000_0000;
  endfunction

  // ************************************************************
  // declarations
  // ************************************************************
  // latches and mode field
  logic [55:0] cfgLatch_ff;
  logic [55:0] nxt_cfgLatch;
  logic [7:0]  modeSig_ff;
  logic [7:0]  nxt_modeSig;
  // status flag bits
  logic [7:0]  nxt_status;
  logic        noLoadBit;
  logic        modStuckBit;
  logic        freqRangeBit;
  logic        tamperBit;
  logic        chanSelBit;
  logic        voltTrendBit;
  logic        pinCheckBit;
  logic        invalidBit;
  // record data
  logic [27:0] rec0Data;
  logic [27:0] rec1Data;
  logic [27:0] rec2Data;
  logic [27:0] rec3Data;
  logic [27:0] rec4Data;
  logic [27:0] rec5Data;
  logic [27:0] rec6Data;
  logic [27:0] rec7Data;
  logic [27:0] recSelData;
  logic [31:0] nxt_recRdData;
  // control and decode
  logic        clearAll;
  logic        clearStatus;
  logic        cfgAddrOk;
  logic        cfgWrEn;
  logic        modeWrEn;
  logic        nxt_clkRange;
  logic        nxt_oscType;
  logic        nxt_sensorType;
  logic        nxt_tamperEn;

  // ************************************************************
  // reset and write qualification
  // ************************************************************
  // remote reset clears latches like power-on
  assign clearAll    = !resetn || remoteReset;
  // status is no latch: only power-on clears it
  assign clearStatus = !resetn;

  // a write racing a clear is lost: clear wins
  assign cfgAddrOk = !cfgAddrRsvd(cfgWrAddr);
  assign cfgWrEn   = cfgWrStb && cfgAddrOk && !clearAll;
  assign modeWrEn  = modeWrStb && !clearAll;

  // ************************************************************
  // configuration latches
  // ************************************************************
  always_comb begin
    nxt_cfgLatch = cfgLatch_ff;
    if (cfgWrEn) begin
      nxt_cfgLatch[cfgWrAddr] = cfgWrVal;
    end
  end

  assign nxt_clkRange   = nxt_cfgLatch[mscr_pkg::CFG_CLK_RANGE];
  assign nxt_oscType    = nxt_cfgLatch[mscr_pkg::CFG_OSC_TYPE];
  assign nxt_sensorType = nxt_cfgLatch[mscr_pkg::CFG_SENSOR];
  assign nxt_tamperEn   = nxt_cfgLatch[mscr_pkg::CFG_TAMPER_EN];

  // ************************************************************
  // mode field
  // ************************************************************
  // only the mode field of the mode record is writable
  always_comb begin
    nxt_modeSig = modeSig_ff;
    if (modeWrEn) begin
      nxt_modeSig = modeWrData;
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  // levels pass through with one cycle of latency
  assign noLoadBit    = noLoadDet;
  assign modStuckBit  = modStuckDet;
  assign freqRangeBit = freqOutOfRange;
  assign tamperBit    = tamperDet;
  assign chanSelBit   = secondaryChanSel;
  assign voltTrendBit = voltSlopeNeg;
  assign pinCheckBit  = pinMismatchDet;
  assign invalidBit   = restartBusy;

  assign nxt_status = {invalidBit, pinCheckBit, voltTrendBit, chanSelBit,
                       tamperBit, freqRangeBit, modStuckBit,
                       noLoadBit};

  // ************************************************************
  // records
  // ************************************************************
  // measurement records have no host write path, except the mode field in record 1
  assign rec0Data = measData[0];
  assign rec1Data = {modeSig_ff, measData[1][19:0]};
  assign rec2Data = measData[2];
  assign rec3Data = measData[3];
  assign rec4Data = measData[4];
  assign rec5Data = measData[5];
  // low half then high half of the latch map
  assign rec6Data = cfgLatch_ff[27:0];
  assign rec7Data = cfgLatch_ff[55:28];

  // ************************************************************
  // read path
  // ************************************************************
  always_comb begin
    recSelData = rec0Data;
    if (recRdIdx == 3'h0) begin
      recSelData = rec0Data;
    end else if (recRdIdx == mscr_pkg::REC_MODE_SIG) begin
      recSelData = rec1Data;
    end else if (recRdIdx == 3'h2) begin
      recSelData = rec2Data;
    end else if (recRdIdx == 3'h3) begin
      recSelData = rec3Data;
    end else if (recRdIdx == 3'h4) begin
      recSelData = rec4Data;
    end else if (recRdIdx == 3'h5) begin
      recSelData = rec5Data;
    end else if (recRdIdx == mscr_pkg::REC_CFG_LOW) begin
      recSelData = rec6Data;
    end else begin
      recSelData = rec7Data;
    end
  end

  // parity is made on the way out, so it matches the data except in the all-zero reset value
  assign nxt_recRdData = mkRecord(recSelData);

  // ************************************************************
  // latch registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      cfgLatch_ff <= mscr_pkg::CFG_RESET;
    end else begin
      cfgLatch_ff <= nxt_cfgLatch;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      modeSig_ff <= mscr_pkg::MODE_RESET;
    end else begin
      modeSig_ff <= nxt_modeSig;
    end
  end

  // ************************************************************
  // status and read data registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (clearStatus) begin
      meterStatusFlags_ff <= mscr_pkg::STATUS_RESET;
    end else begin
      meterStatusFlags_ff <= nxt_status;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clearStatus) begin
      recRdData_ff <= 32'h0000_0000;
    end else begin
      recRdData_ff <= nxt_recRdData;
    end
  end

  // ************************************************************
  // decoded configuration outputs
  // ************************************************************
  // copies switch on the same edge as the latch
  // 0: 4 MHz range, 1: 8 MHz range
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      clockRangeSelect_ff <= 1'b0;
    end else begin
      clockRangeSelect_ff <= nxt_clkRange;
    end
  end

  // 0: crystal, 1: internal RC oscillator
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      oscillatorTypeSelect_ff <= 1'b0;
    end else begin
      oscillatorTypeSelect_ff <= nxt_oscType;
    end
  end

  // meaning depends on the tamper enable bit
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      currentSensorType_ff <= 1'b0;
    end else begin
      currentSensorType_ff <= nxt_sensorType;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      tamperEnable_ff <= 1'b0;
    end else begin
      tamperEnable_ff <= nxt_tamperEn;
    end
  end

endmodule

// >>> verification/mscr_bank_monitor.sv
// Purpose: port-level checks on the status, record and config bank
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every bank instance
`timescale 1ns/1ps
module mscr_bank_monitor (
  input wire logic ref_clk, resetn, remoteReset, noLoadDet, modStuckDet,
  input wire logic freqOutOfRange, tamperDet, secondaryChanSel,
  input wire logic voltSlopeNeg, pinMismatchDet, restartBusy,
  input wire logic cfgWrStb, cfgWrVal,
  input wire logic [5:0] cfgWrAddr,
  input wire logic [2:0] recRdIdx,
  input wire logic [27:0] measData [0:5],
  input wire logic [31:0] recRdData_ff,
  input wire logic [7:0] meterStatusFlags_ff,
  input wire logic clockRangeSelect_ff, oscillatorTypeSelect_ff,
  input wire logic currentSensorType_ff, tamperEnable_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire logic [7:0] st = {restartBusy, pinMismatchDet, voltSlopeNeg,
    secondaryChanSel, tamperDet, freqOutOfRange, modStuckDet, noLoadDet};
  wire logic [3:0] sel = {tamperEnable_ff, currentSensorType_ff,
    oscillatorTypeSelect_ff, clockRangeSelect_ff};
  wire logic w = cfgWrStb && !remoteReset;
  wire logic [3:0] par;
  for (genvar k = 0; k < 4; k++) begin : g_par
    assign par[k] = ~^(recRdData_ff[27:0] & (28'h111_1111 << k));
  end
  stat_low_a: assert property ($past(resetn) |->
    meterStatusFlags_ff[3:0] == $past(st[3:0])) else $error("status low");
  stat_high_a: assert property ($past(resetn) |->
    meterStatusFlags_ff[7:4] == $past(st[7:4])) else $error("status high");
  rec_parity_a: assert property ($past(resetn) |->
    recRdData_ff[31:28] == par) else $error("parity nibble");
  rec_data_a: assert property (
    $past(resetn) && $past(recRdIdx) == 3'h0 |->
    recRdData_ff[27:0] == $past(measData[0])) else $error("record data");
  clk_range_a: assert property (w && cfgWrAddr == 6'h01 |=>
    clockRangeSelect_ff == $past(cfgWrVal)) else $error("clock range");
  osc_type_a: assert property (w && cfgWrAddr == 6'h02 |=>
    oscillatorTypeSelect_ff == $past(cfgWrVal)) else $error("osc type");
  sensor_type_a: assert property (w && cfgWrAddr == 6'h05 |=>
    currentSensorType_ff == $past(cfgWrVal)) else $error("sensor type");
  remote_clear_a: assert property (remoteReset |=> sel == 4'h0)
    else $error("remote reset");
  cfg_hold_a: assert property (!cfgWrStb && !remoteReset |=>
    $stable(sel)) else $error("config changed");
endmodule
bind mscr_bank mscr_bank_monitor u_mon (.ref_clk, .resetn, .remoteReset,
  .noLoadDet, .modStuckDet, .freqOutOfRange, .tamperDet, .secondaryChanSel,
  .voltSlopeNeg, .pinMismatchDet, .restartBusy, .cfgWrStb, .cfgWrVal,
  .cfgWrAddr, .recRdIdx, .measData, .recRdData_ff, .meterStatusFlags_ff,
  .clockRangeSelect_ff, .oscillatorTypeSelect_ff, .currentSensorType_ff,
  .tamperEnable_ff);

// >>> verification/mscr_host_model.sv
// Purpose: host side issuing config bit and mode field writes
// Assumes: requests change at the falling edge
// Notes:   address is scrambled between commands, as a real link would
`timescale 1ns/1ps
module mscr_host_model (
  input  wire logic ref_clk,
  output logic      cfgWrStb,
  output logic [5:0] cfgWrAddr,
  output logic      cfgWrVal,
  output logic      modeWrStb,
  output logic [7:0] modeWrData
);
  initial {cfgWrStb, cfgWrAddr, cfgWrVal, modeWrStb, modeWrData} = '0;
  task automatic cfg(input logic [5:0] a, input logic v);
    @(negedge ref_clk) {cfgWrStb, cfgWrAddr, cfgWrVal} = {1'b1, a, v};
    @(negedge ref_clk) {cfgWrStb, cfgWrAddr} = {1'b0, ~a};
  endtask
  task automatic mode(input logic [7:0] d);
    @(negedge ref_clk) {modeWrStb, modeWrData} = {1'b1, d};
    @(negedge ref_clk) {modeWrStb, modeWrData} = {1'b0, ~d};
  endtask
endmodule

// >>> verification/tb_meter_status_config_records.sv
// Purpose: self-checking bench for the status and config latch bank
// Assumes: host model drives the write strobes
// Notes:   all stimulus at the falling edge
`timescale 1ns/1ps
module tb_meter_status_config_records;
  logic ref_clk = 1'b0, resetn = 1'b0, remoteReset = 1'b0;
  logic [7:0] st = 8'h00, stat, modeWrData;
  logic [27:0] meas [0:5];
  logic [2:0] idx = 3'h0;
  logic [5:0] cfgWrAddr;
  logic [31:0] rd;
  logic cfgWrStb, cfgWrVal, modeWrStb, crs, ots, cst, ten;
  int n_fail = 0, checks_done = 0;
  always #12.5 ref_clk = ~ref_clk;
  mscr_host_model host (.ref_clk, .cfgWrStb, .cfgWrAddr, .cfgWrVal,
    .modeWrStb, .modeWrData);
  mscr_bank dut (.ref_clk, .resetn, .remoteReset, .noLoadDet(st[0]),
    .modStuckDet(st[1]), .freqOutOfRange(st[2]), .tamperDet(st[3]),
    .secondaryChanSel(st[4]), .voltSlopeNeg(st[5]), .pinMismatchDet(st[6]),
    .restartBusy(st[7]), .measData(meas), .cfgWrStb, .cfgWrAddr, .cfgWrVal,
    .modeWrStb, .modeWrData, .recRdIdx(idx), .recRdData_ff(rd),
    .meterStatusFlags_ff(stat), .clockRangeSelect_ff(crs),
    .oscillatorTypeSelect_ff(ots), .currentSensorType_ff(cst),
    .tamperEnable_ff(ten));
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [31:0] rec(input logic [27:0] d);
    logic [3:0] p;
    for (int k = 0; k < 4; k++) p[k] = ~^(d & (28'h111_1111 << k));
    return {p, d};
  endfunction
  task automatic rdrec(input logic [2:0] i, input logic [31:0] exp);
    @(negedge ref_clk) idx = i;
    @(negedge ref_clk) chk("record", exp, rd);
  endtask
  task automatic t_status;
    for (int b = 0; b < 8; b++) begin
      @(negedge ref_clk) st = 8'h01 << b;
      @(negedge ref_clk) chk("status", 8'h01 << b, stat);
    end
    st = 8'h00;
    $display("t_status done");
  endtask
  task automatic t_cfg;
    chk("cfg reset", 4'h0, {ten, cst, ots, crs});
    host.cfg(6'h01, 1'b1);
    host.cfg(6'h02, 1'b1);
    host.cfg(6'h05, 1'b1);
    host.cfg(6'h07, 1'b1);
    chk("cfg out", 4'hF, {ten, cst, ots, crs});
    host.cfg(6'h00, 1'b1);
    host.cfg(6'h03, 1'b1);
    rdrec(3'h6, rec(28'h000_00A6));
    host.cfg(6'h28, 1'b1);
    rdrec(3'h7, rec(28'h000_1000));
    @(negedge ref_clk) remoteReset = 1'b1;
    @(negedge ref_clk) remoteReset = 1'b0;
    chk("remote", 4'h0, {ten, cst, ots, crs});
    rdrec(3'h7, rec(28'h000_0000));
    $display("t_cfg done");
  endtask
  task automatic t_rec;
    rdrec(3'h0, rec(meas[0]));
    rdrec(3'h4, rec(meas[4]));
    host.mode(8'h5A);
    rdrec(3'h1, rec({8'h5A, meas[1][19:0]}));
    $display("t_rec done");
  endtask
  initial begin
    #100us;
    n_fail++;
    end_sim();
  end
  initial begin
    for (int k = 0; k < 6; k++) meas[k] = 28'h9A5_C3E1 >> k;
    repeat (3) @(negedge ref_clk);
    chk("reset status", 8'h80, stat);
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    t_status();
    t_cfg();
    t_rec();
    end_sim();
  end
endmodule
